/* inc/wec_pkg.sv */
// Package of constants and types shared by the wake event collector.
package wec_pkg;

  // Bus address width; register indices become byte addresses times four.
  localparam int ADDR_W = 20;

  // Register indices of the wake source registers.
  localparam logic [15:0] IDX_INT_SRC_ONE = 16'h7f02;
  localparam logic [15:0] IDX_WAKE_ONE    = 16'h7f2a;
  localparam logic [15:0] IDX_WAKE_TWO    = 16'h7f2b;
  localparam logic [15:0] IDX_WAKE_EIGHT  = 16'h7f55;
  localparam logic [15:0] IDX_WAKE_FOUR   = 16'h7f59;
  localparam logic [15:0] IDX_WAKE_FIVE   = 16'h7f5e;
  localparam logic [15:0] IDX_WAKE_SIX    = 16'h7f63;
  localparam logic [15:0] IDX_WAKE_SEVEN  = 16'h7f64;

  // Slot order of the wake source array.
  localparam logic [15:0] WAKE_IDX [8] = '{IDX_INT_SRC_ONE, IDX_WAKE_ONE, IDX_WAKE_TWO,
                                          IDX_WAKE_EIGHT, IDX_WAKE_FOUR, IDX_WAKE_FIVE,
                                          IDX_WAKE_SIX, IDX_WAKE_SEVEN};

  // Mask, edge select and sleep control registers.
  localparam logic [15:0] IDX_MASK_BASE = 16'h7f70;
  localparam logic [15:0] IDX_EDGE_BASE = 16'h7f78;
  localparam logic [15:0] IDX_CTRL      = 16'h7f7c;

  // Reset values.
  localparam logic [7:0] WAKE_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] EDGE_RST = 8'h00;

  // Control register bit positions.
  localparam int CTRL_SLEEP_BIT  = 0;
  localparam int CTRL_RING_BIT   = 1;
  localparam int CTRL_ASLEEP_BIT = 2;
  localparam int CTRL_MAIN_BIT   = 3;

  // Bus responses.
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef enum logic [1:0] {
    WEC_RUN    = 2'b00,
    WEC_SLEEP  = 2'b01,
    WEC_RESUME = 2'b10
  } wec_state_t;

  typedef enum logic [2:0] {
    WEC_K_NONE = 3'b000,
    WEC_K_WAKE = 3'b001,
    WEC_K_MASK = 3'b010,
    WEC_K_EDGE = 3'b011,
    WEC_K_CTRL = 3'b100
  } wec_kind_t;

  typedef struct packed {
    wec_kind_t  kind;
    logic [2:0] sel;
  } wec_dec_t;

  // Pins that arrive from outside the clock domain.
  typedef struct packed {
    logic [7:0]  key_scan_inputs;
    logic        infrared_receive_pin;
    logic        ring_indicator_pin_n;
    logic        bus_one_data;
    logic        bus_two_data;
    logic        general_wakeup_input_n;
    logic [6:0]  aux_inputs;
    logic [21:0] gpio_pins;
    logic        floppy_on_parallel_detect;
    logic [7:0]  host_pins;
    logic        main_power_on;
  } wec_pins_t;

  // Levels from logic on the same clock; a rising level is one event.
  typedef struct packed {
    logic clock_alarm_wake;
    logic hibernation_timer_wake;
    logic power_status_wake;
    logic power_enable_wake;
    logic power_control_wake;
    logic fan_one_slow_wake;
    logic fan_two_slow_wake;
  } wec_internal_t;

endpackage

/* rtl/wec_top.sv */
// Wake event collector: pin and internal wake sources, AXI4-Lite registers, sleep control.
//
// Chosen here: the AXI4-Lite slave port.
`timescale 1ns/1ps

// Functional notes
// - Internal sources flag bits in wake source one, two and seven; hibernation shares bit 2 with infrared.
// - General pins wake on a software selected edge, falling after reset.
// - Detection keeps working while the main power plane is off.
// - Detection runs from standby power and while the core sleeps.
// - Falling edge on any key scan input sets any-key bit 1 of 0x7f2b.
// - Falling edge on infrared receive pin sets bit 2 of 0x7f2b.
// - Fan slow detectors set bits 0 and 1 of 0x7f64.
// - Either edge on floppy detect pin sets bit 2 of 0x7f64.
// - Pin 8, also second infrared input, sets bit 2 of 0x7f5e, edge programmable.
// - Pins 11 and 12 set bits 5 and 6 of 0x7f5e.
// - Alternate function activity on a wake pin still raises its wake event.
// - Only the listed pins are wake capable; no others raise events.
// - While asleep only an unmasked wake event ends the sleep.
// - A wake starts the ring oscillator and resumes the core.
module wec_top
  import wec_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire wec_pins_t         pins,
  input  wire wec_internal_t     internal_src,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   irq,
  output logic                   core_sleep,
  output logic                   ring_osc_enable,
  output logic                   core_resume
);

  // Map a byte address onto a register kind and slot.
  function automatic wec_dec_t decode(input logic [ADDR_W-1:0] a);
    wec_dec_t    d;
    logic [15:0] idx;
    d.kind = WEC_K_NONE;
    d.sel  = 3'h0;
    idx    = a[17:2];
    if (a[1:0] == 2'b00 && a[ADDR_W-1:18] == '0) begin
      for (int i = 0; i < 8; i++) begin
        if (idx == WAKE_IDX[i]) begin
          d.kind = WEC_K_WAKE;
          d.sel  = 3'(i);
        end
        if (idx == IDX_MASK_BASE + 16'(i)) begin
          d.kind = WEC_K_MASK;
          d.sel  = 3'(i);
        end
      end
      for (int i = 0; i < 3; i++) begin
        if (idx == IDX_EDGE_BASE + 16'(i)) begin
          d.kind = WEC_K_EDGE;
          d.sel  = 3'(i);
        end
      end
      if (idx == IDX_CTRL) begin
        d.kind = WEC_K_CTRL;
      end
    end
    return d;
  endfunction

  // State.
  wec_pins_t     sync1_reg;
  wec_pins_t     sync2_reg;
  wec_pins_t     prev_reg;
  wec_internal_t int_prev_reg;
  logic [7:0]    wake_reg [8];
  logic [7:0]    wake_next [8];
  logic [7:0]    mask_reg [8];
  logic [7:0]    edge_reg [3];
  logic [7:0]    evt [8];
  wec_state_t    state_reg;
  logic          ring_reg;
  logic          irq_reg;
  logic          resume_reg;
  logic          sleep_reg;
  logic          pending;

  // Bus state.
  logic              awready_reg;
  logic              wready_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              arready_reg;
  logic              rvalid_reg;
  logic [31:0]       rdata_reg;
  logic [1:0]        rresp_reg;
  logic              aw_held_reg;
  logic              w_held_reg;
  logic [ADDR_W-1:0] awaddr_reg;
  logic [7:0]        wbyte_reg;
  logic              wlane_reg;

  // Write decode, shared by all register blocks, and read decode of the live address.
  wec_dec_t wr_dec;
  wec_dec_t rd_dec;
  logic     wr_go;
  logic     wr_en;
  assign wr_dec = decode(awaddr_reg);
  assign rd_dec = decode(s_axi_araddr);
  assign wr_go  = aw_held_reg && w_held_reg && !bvalid_reg;
  assign wr_en  = wr_go && wlane_reg;

  // Two-stage synchroniser plus a history stage; only stage two and history feed logic.
  // The chain runs through reset, so the history matches the pads at release;
  // clearing it would fake an edge on every either-edge pin that idles high.
  // The collector sits on standby power, so it never waits on the main plane.
  always_ff @(posedge aclk) begin
    sync1_reg <= pins;
    sync2_reg <= sync1_reg;
    prev_reg  <= sync2_reg;
  end

  // History of the internal levels, same clock, no synchroniser.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      int_prev_reg <= '0;
    end else begin
      int_prev_reg <= internal_src;
    end
  end

  // Edge detection and mapping onto register bits.
  // Pins are watched at the pad, so whatever function owns a pin, its
  // transitions still count; pins absent here cannot wake at all.
  always_comb begin
    logic [21:0]   gp_rise;
    logic [21:0]   gp_fall;
    logic [21:0]   gp_evt;
    logic [23:0]   edge_bits;
    wec_internal_t irise;
    logic [6:0]    aux_any;
    logic [7:0]    host_any;
    gp_rise   = sync2_reg.gpio_pins & ~prev_reg.gpio_pins;
    gp_fall   = prev_reg.gpio_pins & ~sync2_reg.gpio_pins;
    edge_bits = {edge_reg[2], edge_reg[1], edge_reg[0]};
    gp_evt    = (edge_bits[21:0] & gp_rise) | (~edge_bits[21:0] & gp_fall);
    irise     = internal_src & ~int_prev_reg;
    aux_any   = sync2_reg.aux_inputs ^ prev_reg.aux_inputs;
    host_any  = sync2_reg.host_pins ^ prev_reg.host_pins;
    for (int i = 0; i < 8; i++) begin
      evt[i] = 8'h00;
    end
    // Interrupt source one: only pin 3 lands here.
    evt[0][3] = gp_evt[3];
    // Wake source one: bus data falling edges and power events.
    evt[1][3] = prev_reg.bus_two_data & ~sync2_reg.bus_two_data;
    evt[1][4] = prev_reg.bus_one_data & ~sync2_reg.bus_one_data;
    evt[1][5] = irise.power_status_wake;
    evt[1][6] = irise.power_enable_wake;
    evt[1][7] = irise.power_control_wake;
    // Wake source two.
    evt[2][0] = irise.clock_alarm_wake;
    evt[2][1] = (|(prev_reg.key_scan_inputs & ~sync2_reg.key_scan_inputs)) | aux_any[6];
    evt[2][2] = irise.hibernation_timer_wake
                | (prev_reg.infrared_receive_pin & ~sync2_reg.infrared_receive_pin);
    evt[2][3] = prev_reg.general_wakeup_input_n & ~sync2_reg.general_wakeup_input_n;
    evt[2][4] = aux_any[1];
    evt[2][5] = aux_any[0] | aux_any[2];
    evt[2][6] = prev_reg.ring_indicator_pin_n & ~sync2_reg.ring_indicator_pin_n;
    // Wake source eight: host pins, either edge.
    evt[3] = host_any;
    // Wake source four.
    evt[4] = {gp_evt[4], gp_evt[7], aux_any[5], gp_evt[2], gp_evt[1], gp_evt[0],
              aux_any[4], aux_any[3]};
    // Wake source five: pins 5 to 13 less pin 7.
    evt[5] = {gp_evt[13], gp_evt[12], gp_evt[11], gp_evt[10], gp_evt[9], gp_evt[8],
              gp_evt[6], gp_evt[5]};
    // Wake source six: pins 14 to 21, pin 18 on top.
    evt[6] = {gp_evt[18], gp_evt[21], gp_evt[20], gp_evt[19], gp_evt[17:14]};
    // Wake source seven: fans and floppy detect.
    evt[7][0] = irise.fan_one_slow_wake;
    evt[7][1] = irise.fan_two_slow_wake;
    evt[7][2] = sync2_reg.floppy_on_parallel_detect
                ^ prev_reg.floppy_on_parallel_detect;
  end

  // Sticky flags: write one clears, a new event in the same cycle wins.
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      wake_next[i] = wake_reg[i] | evt[i];
      if (wr_en && wr_dec.kind == WEC_K_WAKE && wr_dec.sel == 3'(i)) begin
        wake_next[i] = (wake_reg[i] & ~wbyte_reg) | evt[i];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 8; i++) begin
        wake_reg[i] <= WAKE_RST;
      end
    end else begin
      for (int i = 0; i < 8; i++) begin
        wake_reg[i] <= wake_next[i];
      end
    end
  end

  // Mask registers, same layout as the wake source registers.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 8; i++) begin
        mask_reg[i] <= MASK_RST;
      end
    end else if (wr_en && wr_dec.kind == WEC_K_MASK) begin
      mask_reg[wr_dec.sel] <= wbyte_reg;
    end
  end

  // Edge select for general pins: one means rising, zero means falling.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 3; i++) begin
        edge_reg[i] <= EDGE_RST;
      end
    end else if (wr_en && wr_dec.kind == WEC_K_EDGE && wr_dec.sel < 3'd3) begin
      edge_reg[wr_dec.sel[1:0]] <= wbyte_reg;
    end
  end

  // Any unmasked flag drives the interrupt and ends a sleep.
  always_comb begin
    pending = 1'b0;
    for (int i = 0; i < 8; i++) begin
      pending = pending | (|(wake_reg[i] & mask_reg[i]));
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= pending;
    end
  end

  // Sleep sequencing. The oscillator is forced off during sleep and started
  // by the wake; firmware switches it off again once it runs on a crystal.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg  <= WEC_RUN;
      ring_reg   <= 1'b0;
      resume_reg <= 1'b0;
      sleep_reg  <= 1'b0;
    end else begin
      resume_reg <= 1'b0;
      unique case (state_reg)
        WEC_RUN: begin
          if (wr_en && wr_dec.kind == WEC_K_CTRL) begin
            ring_reg <= wbyte_reg[CTRL_RING_BIT];
            if (wbyte_reg[CTRL_SLEEP_BIT]) begin
              state_reg <= WEC_SLEEP;
              sleep_reg <= 1'b1;
              ring_reg  <= 1'b0;
            end
          end
        end
        WEC_SLEEP: begin
          if (pending) begin
            state_reg  <= WEC_RESUME;
            sleep_reg  <= 1'b0;
            ring_reg   <= 1'b1;
            resume_reg <= 1'b1;
          end
        end
        WEC_RESUME: begin
          state_reg <= WEC_RUN;
        end
        default: begin
          state_reg <= WEC_RUN;
          sleep_reg <= 1'b0;
        end
      endcase
    end
  end

  // Write channel: address and data are taken in either order, then answered.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_reg <= 1'b1;
      wready_reg  <= 1'b1;
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      awaddr_reg  <= '0;
      wbyte_reg   <= 8'h00;
      wlane_reg   <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && awready_reg) begin
        awaddr_reg  <= s_axi_awaddr;
        aw_held_reg <= 1'b1;
        awready_reg <= 1'b0;
      end
      if (s_axi_wvalid && wready_reg) begin
        wbyte_reg  <= s_axi_wdata[7:0];
        wlane_reg  <= s_axi_wstrb[0];
        w_held_reg <= 1'b1;
        wready_reg <= 1'b0;
      end
      if (wr_go) begin
        bvalid_reg  <= 1'b1;
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bresp_reg   <= (wr_dec.kind == WEC_K_NONE) ? RESP_SLVERR : RESP_OKAY;
      end
      if (bvalid_reg && s_axi_bready) begin
        bvalid_reg  <= 1'b0;
        awready_reg <= 1'b1;
        wready_reg  <= 1'b1;
      end
    end
  end

  // Read channel: one cycle from address to data. Reads have no side effect.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_reg <= 1'b1;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && arready_reg) begin
        arready_reg <= 1'b0;
        rvalid_reg  <= 1'b1;
        rresp_reg   <= RESP_OKAY;
        rdata_reg   <= 32'h0000_0000;
        unique case (rd_dec.kind)
          WEC_K_WAKE: rdata_reg[7:0] <= wake_reg[rd_dec.sel];
          WEC_K_MASK: rdata_reg[7:0] <= mask_reg[rd_dec.sel];
          WEC_K_EDGE: rdata_reg[7:0] <= edge_reg[rd_dec.sel[1:0]];
          WEC_K_CTRL: begin
            rdata_reg[CTRL_RING_BIT]   <= ring_reg;
            rdata_reg[CTRL_ASLEEP_BIT] <= (state_reg == WEC_SLEEP);
            rdata_reg[CTRL_MAIN_BIT]   <= sync2_reg.main_power_on;
          end
          WEC_K_NONE: rresp_reg <= RESP_SLVERR;
          default: rresp_reg <= RESP_SLVERR;
        endcase
      end
      if (rvalid_reg && s_axi_rready) begin
        rvalid_reg  <= 1'b0;
        arready_reg <= 1'b1;
      end
    end
  end

  // Outputs straight from flip-flops.
  assign s_axi_awready   = awready_reg;
  assign s_axi_wready    = wready_reg;
  assign s_axi_bvalid    = bvalid_reg;
  assign s_axi_bresp     = bresp_reg;
  assign s_axi_arready   = arready_reg;
  assign s_axi_rvalid    = rvalid_reg;
  assign s_axi_rdata     = rdata_reg;
  assign s_axi_rresp     = rresp_reg;
  assign irq             = irq_reg;
  assign core_sleep      = sleep_reg;
  assign ring_osc_enable = ring_reg;
  assign core_resume     = resume_reg;

endmodule

/* testbench/tb_top.sv */
// Self-checking bench for the wake event collector.
`timescale 1ns/1ps
module tb_top;
  import wec_pkg::*;
  logic              aclk = 1'b0;
  logic              aresetn = 1'b0;
  wec_pins_t         pins_want = '0;
  wec_internal_t     int_want = '0;
  wec_pins_t         pins;
  wec_internal_t     internal_src;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic [31:0]       wdata = '0;
  logic              awvalid = 1'b0;
  logic              wvalid = 1'b0;
  logic              bready = 1'b0;
  logic              arvalid = 1'b0;
  logic              rready = 1'b0;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [1:0]        bresp, rresp, rsp;
  logic [31:0]       rdata, rd;
  logic              irq, core_sleep, ring_osc_enable, core_resume;
  int                n_errors = 0;
  int                checks_done = 0;
  int                n;

  always #5 aclk = ~aclk;

  wec_wake_model u_src (.aclk, .pins_want, .int_want, .pins, .internal_src);

  wec_top u_dut (
    .aclk, .aresetn, .pins, .internal_src,
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .irq, .core_sleep, .ring_osc_enable, .core_resume
  );

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic final_report;
    if (n_errors == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Write one register; address and data are offered together.
  task automatic wr(input logic [15:0] idx, input logic [7:0] d);
    int k;
    @(posedge aclk);
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    rsp = bresp;
    if (k == 40) begin
      n_errors++;
      final_report();
    end
  endtask

  // Read one register into rd and rsp.
  task automatic rdr(input logic [15:0] idx);
    int k;
    @(posedge aclk);
    araddr <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    rd = rdata;
    rsp = rresp;
    if (k == 40) begin
      n_errors++;
      final_report();
    end
  endtask

  // Let a pin change pass the synchroniser, compare the flags, then clear them.
  task automatic pin_chk(input logic [15:0] idx, input logic [7:0] exp);
    repeat (8) @(posedge aclk);
    rdr(idx);
    chk(rd, {24'h0, exp});
    wr(idx, 8'hff);
  endtask

  // Cut a hung run short.
  initial begin
    repeat (30000) @(posedge aclk);
    n_errors++;
    final_report();
  end

  initial begin
    logic [15:0] ireg [7];
    logic [7:0]  ibit [7];
    ireg = '{IDX_WAKE_TWO, IDX_WAKE_TWO, IDX_WAKE_ONE, IDX_WAKE_ONE, IDX_WAKE_ONE,
             IDX_WAKE_SEVEN, IDX_WAKE_SEVEN};
    ibit = '{8'h01, 8'h04, 8'h20, 8'h40, 8'h80, 8'h01, 8'h02};
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      rdr(WAKE_IDX[i]);
      chk(rd, 32'h0);
    end
    rdr(16'h0000);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    wr(16'h0000, 8'hff);
    chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
    // Park falling-edge pins high first; the main plane stays off throughout.
    pins_want.key_scan_inputs <= 8'hff;
    pins_want.infrared_receive_pin <= 1'b1;
    pins_want.gpio_pins <= 22'h3fffff;
    repeat (8) @(posedge aclk);
    for (int i = 0; i < 8; i++) wr(WAKE_IDX[i], 8'hff);
    // Each internal source rises once; its flag must outlive the level.
    for (int i = 0; i < 7; i++) begin
      int_want <= wec_internal_t'(7'h40 >> i);
      repeat (4) @(posedge aclk);
      int_want <= '0;
      pin_chk(ireg[i], ibit[i]);
      rdr(ireg[i]);
      chk(rd, 32'h0);
    end
    pins_want.key_scan_inputs[5] <= 1'b0;
    pin_chk(IDX_WAKE_TWO, 8'h02);
    pins_want.key_scan_inputs[5] <= 1'b1;
    pin_chk(IDX_WAKE_TWO, 8'h00);
    pins_want.infrared_receive_pin <= 1'b0;
    pin_chk(IDX_WAKE_TWO, 8'h04);
    pins_want.floppy_on_parallel_detect <= 1'b1;
    pin_chk(IDX_WAKE_SEVEN, 8'h04);
    pins_want.floppy_on_parallel_detect <= 1'b0;
    pin_chk(IDX_WAKE_SEVEN, 8'h04);
    for (int i = 0; i < 8; i++) begin
      pins_want.host_pins[i] <= 1'b1;
      pin_chk(IDX_WAKE_EIGHT, 8'h01 << i);
    end
    pins_want.host_pins <= 8'h00;
    pin_chk(IDX_WAKE_EIGHT, 8'hff);
    pins_want.gpio_pins[8] <= 1'b0;
    pin_chk(IDX_WAKE_FIVE, 8'h04);
    pins_want.gpio_pins[12:11] <= 2'b00;
    pin_chk(IDX_WAKE_FIVE, 8'h60);
    // Pin 8 switched to rising edge: only the rise counts now.
    wr(IDX_EDGE_BASE + 16'h1, 8'h01);
    pins_want.gpio_pins[8] <= 1'b1;
    pin_chk(IDX_WAKE_FIVE, 8'h04);
    pins_want.gpio_pins[8] <= 1'b0;
    pin_chk(IDX_WAKE_FIVE, 8'h00);
    // Only fan one is unmasked; fan two must neither interrupt nor wake.
    wr(IDX_MASK_BASE + 16'h7, 8'h01);
    wr(IDX_CTRL, 8'h01);
    int_want.fan_two_slow_wake <= 1'b1;
    repeat (10) @(negedge aclk);
    chk({30'h0, core_sleep, irq}, 32'h2);
    chk({31'h0, ring_osc_enable}, 32'h0);
    @(posedge aclk);
    int_want.fan_one_slow_wake <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(negedge aclk);
      if (core_resume === 1'b1) break;
    end
    if (n == 20) begin
      n_errors++;
      final_report();
    end
    chk({30'h0, ring_osc_enable, core_sleep}, 32'h2);
    repeat (3) @(negedge aclk);
    chk({31'h0, irq}, 32'h1);
    rdr(IDX_CTRL);
    chk(rd, 32'h2);
    int_want <= '0;
    wr(IDX_WAKE_SEVEN, 8'hff);
    repeat (3) @(negedge aclk);
    chk({31'h0, irq}, 32'h0);
    final_report();
  end
endmodule

bind wec_top wec_assertions u_chk (
  .aclk, .aresetn, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .core_sleep,
  .ring_osc_enable, .core_resume
);

/* testbench/wec_assertions.sv */
// Port checker for the wake event collector.
`timescale 1ns/1ps
module wec_assertions
  import wec_pkg::*;
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        core_sleep,
  input wire logic        ring_osc_enable,
  input wire logic        core_resume
);
  // One clock domain, so clock and reset are stated once.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Leaving sleep is two steps: asleep, then awake on the next edge.
  sequence s_exit;
    core_sleep ##1 !core_sleep;
  endsequence

  a_read_latency: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> $stable(s_axi_rdata))
    else $error("read data moved");
  a_flag_width: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  a_exit_resume: assert property (s_exit |-> core_resume)
    else $error("sleep left without resume");
  a_exit_ring: assert property (s_exit |-> ring_osc_enable)
    else $error("ring oscillator off at wake");
  a_resume_pulse: assert property (core_resume |=> !core_resume && !core_sleep)
    else $error("resume not one cycle");
  a_sleep_ring_off: assert property (core_sleep |-> !ring_osc_enable)
    else $error("ring runs while asleep");
endmodule

/* testbench/wec_wake_model.sv */
// Far side model: wake pads and internal detectors driving the collector.
`timescale 1ns/1ps
module wec_wake_model
  import wec_pkg::*;
(
  input  wire logic          aclk,
  input  wire wec_pins_t     pins_want,
  input  wire wec_internal_t int_want,
  output wec_pins_t          pins,
  output wec_internal_t      internal_src
);
  wec_pins_t     pins_q = '0;
  wec_internal_t int_q  = '0;

  // Pads follow the request one clock later, like a slow board driver.
  always @(posedge aclk) begin
    pins_q <= pins_want;
  end

  // Timer, power and fan detectors change on the block clock as levels.
  always @(posedge aclk) begin
    int_q <= int_want;
  end

  assign pins         = pins_q;
  assign internal_src = int_q;
endmodule
